// >>> tb_tcc_core.sv
`timescale 1ns/1ps
module tb_tcc_core;
    import tcc_pkg::*;
    logic          core_clk;
    logic          sys_rst;
    logic          manual_rst;
    tcc_bus_req_t  bus_req;
    logic [7:0]    bus_rdata;
    tcc_chan_evt_t evt [5];
    logic [3:0]    ext_clk_pins;
    logic [4:0]    phase_step;
    logic [4:0]    phase_up;
    logic [4:0]    count_tick;
    logic [4:0]    count_clear;
    logic [4:0]    overflow;
    int            bad_count;
    int            compares;
    int            hp [4] = '{3, 4, 5, 7};
    int            pc [4] = '{0, 0, 0, 0};
    int            m [6];
    int            nt [5];
    int            nc [5];
    int            nv [5];
    logic [7:0]    v;
    // Divider per code and channel, pins as -1 to -4, 0 untested
    int src [5][8] = '{'{1, 4, 16, 64, -1, -2, -3, -4},
        '{1, 4, 16, 64, -1, -2, 256, 0}, '{1, 4, 16, 64, -1, -2, -3, 1024},
        '{1, 4, 16, 64, 256, 1024, -1, -2}, '{1, 4, 16, 64, 256, 1024, -1, -2}};

    tcc_core DUT (
        .core_clk     (core_clk),
        .sys_rst      (sys_rst),
        .manual_rst   (manual_rst),
        .bus_req      (bus_req),
        .bus_rdata    (bus_rdata),
        .evt          (evt),
        .ext_clk_pins (ext_clk_pins),
        .phase_step   (phase_step),
        .phase_up     (phase_up),
        .count_tick   (count_tick),
        .count_clear  (count_clear),
        .overflow     (overflow)
    );

    // Clock
    initial
    begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    // Pins toggle every 3, 4, 5 and 7 cycles
    always @(posedge core_clk)
    begin
        for (int k = 0; k < 4; k++)
        begin
            pc[k] = (pc[k] + 1) % hp[k];
            if (pc[k] == 0)
                ext_clk_pins[k] <= ~ext_clk_pins[k];
        end
    end

    task chk(input logic [15:0] s, input logic [15:0] e);
        compares++;
        if (s !== e)
        begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, s, e);
        end
    endtask : chk

    task wr(input logic [3:0] a, input logic [7:0] d);
        bus_req.addr <= a;
        bus_req.wdata <= d;
        bus_req.wr <= 1'b1;
        @(posedge core_clk);
        bus_req.wr <= 1'b0;
        @(posedge core_clk);
    endtask : wr

    task rd(input logic [3:0] a, input logic [7:0] e);
        bus_req.addr <= a;
        bus_req.rd <= 1'b1;
        @(posedge core_clk);
        bus_req.rd <= 1'b0;
        #1 chk(16'(bus_rdata), 16'(e));
        @(posedge core_clk);
    endtask : rd

    task rst;
        sys_rst <= 1'b1;
        repeat (6) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
    endtask : rst

    task mpulse;
        manual_rst <= 1'b1;
        @(posedge core_clk);
        manual_rst <= 1'b0;
        @(posedge core_clk);
    endtask : mpulse

    // Cycles between two ticks of one channel
    task per(input int c, output int p);
        int n;
        n = 0;
        p = 0;
        repeat (4) @(posedge core_clk);
        do
        begin
            @(negedge core_clk);
            n++;
        end while (count_tick[c] !== 1'b1 && n < 3000);
        do
        begin
            @(negedge core_clk);
            p++;
        end while (count_tick[c] !== 1'b1 && p < 3000);
        @(posedge core_clk);
    endtask : per

    // Ticks and clears summed over a window
    task sum(input int w);
        nt = '{default: 0};
        nc = '{default: 0};
        nv = '{default: 0};
        repeat (w)
        begin
            @(negedge core_clk);
            foreach (nt[i])
            begin
                nt[i] += count_tick[i];
                nc[i] += count_clear[i];
                nv[i] += overflow[i];
            end
        end
        @(posedge core_clk);
    endtask : sum

    task results;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : results

    // Watchdog, well past the longest expected run
    initial
    begin
        #1500000;
        bad_count++;
        results();
    end

    initial
    begin
        sys_rst = 1'b1;
        manual_rst = 1'b0;
        bus_req = '0;
        evt = '{default: '0};
        ext_clk_pins = 4'h0;
        phase_step = 5'h00;
        phase_up = 5'h00;
        void'($urandom(32'h82f6));
        rst();
        // Reset values, masking, manual and full reset
        for (int r = 0; r < 4; r++)
        begin
            for (int i = 0; i < 6; i++)
                rd(4'(i), (r % 3 == 0 || i == 5) ? 8'h00 : 8'(m[i]));
            if (r == 0)
                for (int i = 0; i < 6; i++)
                begin
                    v = 8'($urandom);
                    wr(4'(i), v);
                    m[i] = (i == 1 || i == 2) ? v & 8'h7f : v;
                end
            if (r == 1)
                mpulse();
            if (r == 2)
                rst();
        end
        // Clear source decode under random buffering
        for (int c = 0; c < 2; c++)
            for (int k = 0; k < 8; k++)
                for (int e = 0; e < 6; e++)
                begin
                    int f;
                    int b;
                    b = $urandom % 2;
                    f = c ? k % 4 : k;
                    wr(4'(c), 8'(k << 5));
                    evt[c] <= tcc_chan_evt_t'((e < 4 ? 9'h100 >> e
                        : e == 4 ? 9'h002 : 9'h006) | (b ? 9'h018 : 9'h000));
                    @(posedge core_clk);
                    evt[c] <= '0;
                    sum(4);
                    chk(16'(nc[c]), 16'((f % 4 == 3) ? e == 5 : (f % 4 != 0
                        && f % 4 - 1 + 2 * (f / 4) == e && !(b && e > 1))));
                end
        // Tick period for every source but the channel 1 overflow clock, and each edge choice
        for (int c = 0; c < 5; c++)
            for (int k = 0; k < 8; k++)
                for (int g = 0; g < 3; g++)
                begin
                    int d;
                    int p;
                    d = src[c][k];
                    if (d != 0)
                    begin
                        wr(4'(c), 8'(g * 8 + k));
                        per(c, p);
                        chk(16'(p), 16'(d < 0 ? hp[-d - 1] * (g == 2 ? 1 : 2)
                            : d < 4 ? 1 : g == 2 ? d / 2 : d));
                    end
                end
        // Phase steps on 2 wrap every time and clock 1
        wr(4'h1, 8'h17);
        wr(4'h2, 8'h10);
        evt[2] <= tcc_chan_evt_t'(9'h001);
        mpulse();
        for (int i = 0; i < 6; i++)
        begin
            phase_up[2] <= i[0];
            phase_step[2] <= 1'b1;
            @(posedge core_clk);
            phase_step[2] <= 1'b0;
            sum(8);
            chk(16'(nt[2]), 16'h0001);
            chk(16'(nt[1]), 16'h0001);
            chk(16'(nv[2]), 16'h0001);
            rd(4'hb, i[0] ? 8'h00 : 8'hff);
        end
        results();
    end
endmodule : tb_tcc_core

bind tcc_core tcc_core_monitor #(.NCH(NCH)) mon (
    .core_clk     (core_clk),
    .sys_rst      (sys_rst),
    .manual_rst   (manual_rst),
    .bus_req      (bus_req),
    .bus_rdata    (bus_rdata),
    .evt          (evt),
    .ext_clk_pins (ext_clk_pins),
    .count_tick   (count_tick),
    .count_clear  (count_clear)
);

// >>> tcc_core.sv
// Decided for this implementation: the plain strobed port and the register offsets.
`timescale 1ns/1ps
// What this block does
// - Each channel owns one 8-bit control register
// - Reset loads zero; manual reset keeps contents
// - Channels 0,3,4: three-bit clear source select
// - Channels 1,2: two-bit clear, bit7 reads zero
// - Sync clear only when sync bit set
// - Buffered C or D never clears counter
// - Edge field: rising, falling, or both edges
// - Both edges of a divided internal clock double the count rate
// - Undivided or overflow clock counts rising only
// - Phase counting ignores edge select on 1,2
// - Each channel selects its own clock source
// - Channel 0 prescaler code map
// - Channel 1 prescaler code map
// - Channel 2 prescaler code map
// - Phase counting ignores prescaler on 1,2
// - Channels 3,4 prescaler code map
`include "tcc_params.svh"

module tcc_core #(
    parameter int NCH     = 5,
    parameter int CNT_W   = 16,
    parameter int DIV_W   = 10
) (
    input  wire logic                  core_clk,
    input  wire logic                  sys_rst,
    input  wire logic                  manual_rst,
    input  wire tcc_pkg::tcc_bus_req_t bus_req,
    output logic [7:0]                 bus_rdata,
    input  wire tcc_pkg::tcc_chan_evt_t evt [NCH],
    input  wire logic [3:0]            ext_clk_pins,
    input  wire logic [NCH-1:0]        phase_step,
    input  wire logic [NCH-1:0]        phase_up,
    output logic [NCH-1:0]             count_tick,
    output logic [NCH-1:0]             count_clear,
    output logic [NCH-1:0]             overflow
);
    import tcc_pkg::*;

    logic [7:0]       ctrl_q [NCH];
    logic [CNT_W-1:0] cnt_q [NCH];
    logic [DIV_W-1:0] div_q;
    logic [DIV_W-1:0] div_prev_q;
    logic [3:0]       pin_meta_q;
    logic [3:0]       pin_sync_q;
    logic [3:0]       pin_prev_q;
    logic [3:0]       pin_rise;
    logic [3:0]       pin_fall;
    logic [NCH-1:0]   tick_d;
    logic [NCH-1:0]   clr_d;
    logic [NCH-1:0]   ovf_d;
    logic [NCH-1:0]   tick_q;
    logic [NCH-1:0]   clr_q;
    logic [NCH-1:0]   ovf_q;
    logic [7:0]       rdata_d;

    // Free-running prescaler divider
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            div_q      <= '0;
            div_prev_q <= '0;
        end
        else
        begin
            div_q      <= div_q + 1'b1;
            div_prev_q <= div_q;
        end
    end

    // Two-stage synchroniser for the external clock pins
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            pin_meta_q <= '0;
            pin_sync_q <= '0;
            pin_prev_q <= '0;
        end
        else
        begin
            pin_meta_q <= ext_clk_pins;
            pin_sync_q <= pin_meta_q;
            pin_prev_q <= pin_sync_q;
        end
    end

    // Edges seen only on synchronised samples
    assign pin_rise = pin_sync_q & ~pin_prev_q;
    assign pin_fall = ~pin_sync_q & pin_prev_q;

    // Control registers; manual reset does not touch them
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            for (int i = 0; i < NCH; i++)
                ctrl_q[i] <= `TCC_CTRL_RESET;
        end
        else if (bus_req.wr && bus_req.addr < 4'(NCH))
        begin
            ctrl_q[bus_req.addr[2:0]] <= bus_req.wdata;
            if (bus_req.addr == `TCC_OFS_CTRL1 ||
                bus_req.addr == `TCC_OFS_CTRL2)
                ctrl_q[bus_req.addr[2:0]][`TCC_RSVD_BIT] <= 1'b0;
        end
    end

    // Per-channel clock selection, edge and clear decode
    genvar g;
    generate
        for (g = 0; g < NCH; g++)
        begin : g_ch
            logic [2:0]   psc;
            logic [1:0]   edg;
            logic [2:0]   clr;
            logic         src_lvl_now;
            logic         src_lvl_old;
            logic         src_pulse;
            logic         src_int;
            logic         rise_only;
            logic         pin_r;
            logic         pin_f;
            logic         tick;
            tcc_clr_src_t csrc;

            assign psc = ctrl_q[g][`TCC_PSC_MSB:`TCC_PSC_LSB];
            assign edg = ctrl_q[g][`TCC_EDGE_MSB:`TCC_EDGE_LSB];
            assign clr = ctrl_q[g][`TCC_CLR_MSB:`TCC_CLR_LSB];

            // Source decode per channel code map
            always_comb
            begin
                src_lvl_now = 1'b0;
                src_lvl_old = 1'b0;
                src_pulse   = 1'b0;
                src_int     = 1'b1;
                rise_only   = 1'b0;
                pin_r       = 1'b0;
                pin_f       = 1'b0;
                case (psc)
                    3'h0:
                    begin
                        src_pulse = 1'b1;
                        rise_only = 1'b1;
                    end
                    3'h1:
                    begin
                        src_lvl_now = div_q[`TCC_TAP_DIV4];
                        src_lvl_old = div_prev_q[`TCC_TAP_DIV4];
                    end
                    3'h2:
                    begin
                        src_lvl_now = div_q[`TCC_TAP_DIV16];
                        src_lvl_old = div_prev_q[`TCC_TAP_DIV16];
                    end
                    3'h3:
                    begin
                        src_lvl_now = div_q[`TCC_TAP_DIV64];
                        src_lvl_old = div_prev_q[`TCC_TAP_DIV64];
                    end
                    default:
                    begin
                        src_int = 1'b0;
                        if (g == 0)
                        begin
                            pin_r = pin_rise[psc[1:0]];
                            pin_f = pin_fall[psc[1:0]];
                        end
                        else if (g == 1 && psc[1])
                        begin
                            if (psc[0])
                            begin
                                src_int   = 1'b1;
                                src_pulse = ovf_q[2];
                                rise_only = 1'b1;
                            end
                            else
                            begin
                                src_int     = 1'b1;
                                src_lvl_now = div_q[`TCC_TAP_DIV256];
                                src_lvl_old = div_prev_q[`TCC_TAP_DIV256];
                            end
                        end
                        else if (g == 2 && psc == 3'h7)
                        begin
                            src_int     = 1'b1;
                            src_lvl_now = div_q[`TCC_TAP_DIV1024];
                            src_lvl_old = div_prev_q[`TCC_TAP_DIV1024];
                        end
                        else if (g >= 3 && !psc[1])
                        begin
                            src_int = 1'b1;
                            src_lvl_now = psc[0] ?
                                div_q[`TCC_TAP_DIV1024] :
                                div_q[`TCC_TAP_DIV256];
                            src_lvl_old = psc[0] ?
                                div_prev_q[`TCC_TAP_DIV1024] :
                                div_prev_q[`TCC_TAP_DIV256];
                        end
                        else if (g >= 3)
                        begin
                            pin_r = pin_rise[{1'b0, psc[0]}];
                            pin_f = pin_fall[{1'b0, psc[0]}];
                        end
                        else
                        begin
                            pin_r = pin_rise[psc[1:0]];
                            pin_f = pin_fall[psc[1:0]];
                        end
                    end
                endcase
            end

            // Edge qualification; both edges doubles rate
            always_comb
            begin
                tick = 1'b0;
                if (rise_only)
                    tick = src_pulse;
                else if (src_int)
                begin
                    if (edg[1])
                        tick = src_lvl_now ^ src_lvl_old;
                    else if (edg[0])
                        tick = src_lvl_old & ~src_lvl_now;
                    else
                        tick = src_lvl_now & ~src_lvl_old;
                end
                else if (edg[1])
                    tick = pin_r | pin_f;
                else if (edg[0])
                    tick = pin_f;
                else
                    tick = pin_r;
                // Phase counting overrides source and edge
                if ((g == 1 || g == 2) && evt[g].phase_mode)
                    tick = phase_step[g];
            end

            // Clear source decode
            always_comb
            begin
                case ((g == 1 || g == 2) ? {1'b0, clr[1:0]} : clr)
                    3'h1:    csrc = TCC_CLR_A;
                    3'h2:    csrc = TCC_CLR_B;
                    3'h3:    csrc = TCC_CLR_SYNC;
                    3'h5:    csrc = TCC_CLR_C;
                    3'h6:    csrc = TCC_CLR_D;
                    3'h7:    csrc = TCC_CLR_SYNC;
                    default: csrc = TCC_CLR_NONE;
                endcase
                case (csrc)
                    TCC_CLR_A: clr_d[g] = evt[g].match_a;
                    TCC_CLR_B: clr_d[g] = evt[g].match_b;
                    TCC_CLR_C: clr_d[g] = evt[g].match_c &
                                          ~evt[g].buf_c;
                    TCC_CLR_D: clr_d[g] = evt[g].match_d &
                                          ~evt[g].buf_d;
                    TCC_CLR_SYNC: clr_d[g] = evt[g].sync_en &
                                             evt[g].sync_clr;
                    default:   clr_d[g] = 1'b0;
                endcase
            end

            assign tick_d[g] = tick;

            // Channel counter
            always_ff @(posedge core_clk)
            begin
                if (sys_rst || manual_rst)
                    cnt_q[g] <= '0;
                else if (clr_d[g])
                    cnt_q[g] <= '0;
                else if (tick)
                begin
                    if ((g == 1 || g == 2) && evt[g].phase_mode &&
                        !phase_up[g])
                        cnt_q[g] <= cnt_q[g] - 1'b1;
                    else
                        cnt_q[g] <= cnt_q[g] + 1'b1;
                end
            end

            // Overflow or underflow on wrap
            always_comb
            begin
                ovf_d[g] = 1'b0;
                if (!clr_d[g] && tick)
                begin
                    if ((g == 1 || g == 2) && evt[g].phase_mode &&
                        !phase_up[g])
                        ovf_d[g] = (cnt_q[g] == '0);
                    else
                        ovf_d[g] = (cnt_q[g] == '1);
                end
            end
        end
    endgenerate

    // Registered outputs
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            tick_q <= '0;
            clr_q  <= '0;
            ovf_q  <= '0;
        end
        else
        begin
            tick_q <= tick_d;
            clr_q  <= clr_d;
            ovf_q  <= ovf_d;
        end
    end

    assign count_tick  = tick_q;
    assign count_clear = clr_q;
    assign overflow    = ovf_q;

    // Read mux
    always_comb
    begin
        rdata_d = 8'h00;
        if (bus_req.addr < 4'(NCH))
            rdata_d = ctrl_q[bus_req.addr[2:0]];
        else if (bus_req.addr == `TCC_OFS_STATUS)
            rdata_d = 8'({tick_q});
        else if (bus_req.addr >= `TCC_OFS_CNT0 &&
                 bus_req.addr <= `TCC_OFS_CNT4)
            rdata_d = cnt_q[3'(bus_req.addr - `TCC_OFS_CNT0)][7:0];
    end

    // Read data stand one cycle after the strobe
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            bus_rdata <= 8'h00;
        else if (bus_req.rd)
            bus_rdata <= rdata_d;
        else
            bus_rdata <= 8'h00;
    end

endmodule : tcc_core

// >>> tcc_core_monitor.sv
`timescale 1ns/1ps
module tcc_core_monitor #(
    parameter int NCH = 5
) (
    input wire logic                   core_clk,
    input wire logic                   sys_rst,
    input wire logic                   manual_rst,
    input wire tcc_pkg::tcc_bus_req_t  bus_req,
    input wire logic [7:0]             bus_rdata,
    input wire tcc_pkg::tcc_chan_evt_t evt [NCH],
    input wire logic [3:0]             ext_clk_pins,
    input wire logic [NCH-1:0]         count_tick,
    input wire logic [NCH-1:0]         count_clear
);
    import tcc_pkg::*;
    logic [7:0] ctl_q [NCH];

    // Shadow of the control registers, bit 7 dropped on 1 and 2
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            ctl_q <= '{default: 8'h00};
        else if (bus_req.wr && bus_req.addr < 4'h5)
            ctl_q[bus_req.addr] <= bus_req.wdata
                & ((bus_req.addr inside {1, 2}) ? 8'h7f : 8'hff);
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);

    sequence div4_on;
        (ctl_q[0] == 8'h01) [*3];
    endsequence
    sequence pin_rise;
        ctl_q[0] == 8'h04 ##0 $rose(ext_clk_pins[0]);
    endsequence

    rdata_idle_a: assert property (!bus_req.rd |=> bus_rdata == 8'h00)
        else $error("read data not zero when idle");
    ctrl_read_a: assert property (bus_req.rd && bus_req.addr < 4'h5
        |=> bus_rdata == $past(ctl_q[bus_req.addr]))
        else $error("control readback wrong");
    rsvd_bit_a: assert property (bus_req.rd &&
        bus_req.addr inside {1, 2} |=> !bus_rdata[7])
        else $error("reserved bit reads one");
    reset_quiet_a: assert property ($fell(sys_rst)
        |-> count_tick == '0 && count_clear == '0)
        else $error("outputs active after reset");
    clr_match_a: assert property (evt[0].match_a &&
        ctl_q[0][7:5] == 3'b001 |=> count_clear[0])
        else $error("clear on match a missing");
    buf_hold_a: assert property (ctl_q[0][7:5] == 3'b101 &&
        evt[0].buf_c && !manual_rst |=> !count_clear[0])
        else $error("buffered register cleared counter");
    sync_clr_a: assert property (ctl_q[0][7:5] == 3'b011 &&
        evt[0].sync_clr && !manual_rst
        |=> count_clear[0] == $past(evt[0].sync_en))
        else $error("synchronous clear wrong");
    div1_run_a: assert property ((ctl_q[0][7:5] == 3'b000 &&
        ctl_q[0][2:0] == 3'b000 && !manual_rst) [*4] |-> count_tick[0])
        else $error("undivided clock tick missing");
    div4_gap_a: assert property (div4_on ##0 count_tick[0]
        |=> !count_tick[0] [*3])
        else $error("divide by four ticks too close");
    pin_tick_a: assert property (pin_rise |-> ##[1:4] count_tick[0])
        else $error("pin edge gave no tick");
endmodule : tcc_core_monitor

// >>> tcc_params.svh
`ifndef TCC_PARAMS_SVH
`define TCC_PARAMS_SVH

// Register indices of the five count control registers
`define TCC_OFS_CTRL0 4'h0
`define TCC_OFS_CTRL1 4'h1
`define TCC_OFS_CTRL2 4'h2
`define TCC_OFS_CTRL3 4'h3
`define TCC_OFS_CTRL4 4'h4
// Status word: registered channel count ticks, then counter low bytes
`define TCC_OFS_STATUS 4'h8
`define TCC_OFS_CNT0 4'h9
`define TCC_OFS_CNT1 4'ha
`define TCC_OFS_CNT2 4'hb
`define TCC_OFS_CNT3 4'hc
`define TCC_OFS_CNT4 4'hd

// Field positions
`define TCC_CLR_MSB 7
`define TCC_CLR_LSB 5
`define TCC_EDGE_MSB 4
`define TCC_EDGE_LSB 3
`define TCC_PSC_MSB 2
`define TCC_PSC_LSB 0
`define TCC_RSVD_BIT 7

// Reset value
`define TCC_CTRL_RESET 8'h00

// Prescaler tap positions on a free-running divider
`define TCC_TAP_DIV4 1
`define TCC_TAP_DIV16 3
`define TCC_TAP_DIV64 5
`define TCC_TAP_DIV256 7
`define TCC_TAP_DIV1024 9

`endif

// >>> tcc_pkg.sv
package tcc_pkg;

    // Decoded clear sources
    typedef enum logic [2:0] {
        TCC_CLR_NONE,
        TCC_CLR_A,
        TCC_CLR_B,
        TCC_CLR_C,
        TCC_CLR_D,
        TCC_CLR_SYNC
    } tcc_clr_src_t;

    // Per-channel compare or capture events from outside
    typedef struct packed {
        logic match_a;
        logic match_b;
        logic match_c;
        logic match_d;
        logic buf_c;
        logic buf_d;
        logic sync_en;
        logic sync_clr;
        logic phase_mode;
    } tcc_chan_evt_t;

    // Register port
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } tcc_bus_req_t;

endpackage : tcc_pkg
